// *** design/seq_cfg_pkg.sv ***
// constants shared by the sequencer configuration and status register bank
// assumes a single 50 MHz clock and a plain register access port
package seq_cfg_pkg;

  // clock rate, cycles per microsecond
  localparam int CLK_MHZ = 50;

  // register addresses and the offset of the nonvolatile copy
  localparam logic [7:0] ADDR_FAULT_TIMEOUT = 8'h0a;
  localparam logic [7:0] ADDR_RAMP_ONE_TWO = 8'h0b;
  localparam logic [7:0] ADDR_RAMP_THREE_FOUR = 8'h0c;
  localparam logic [7:0] ADDR_OC_THRESHOLD = 8'h0d;
  localparam logic [7:0] ADDR_OC_TIMER_ENABLE = 8'h0e;
  localparam logic [7:0] ADDR_GATE_DELAY_FLAGS = 8'h0f;
  localparam logic [7:0] ADDR_PG_THRESHOLD = 8'h10;
  localparam logic [7:0] NV_OFFSET = 8'h20;
  localparam int NUM_REGS = 7;
  localparam int NUM_CH = 4;

  // register indices, address minus the first address
  localparam logic [2:0] IDX_FAULT = 3'h0;
  localparam logic [2:0] IDX_RAMP12 = 3'h1;
  localparam logic [2:0] IDX_RAMP34 = 3'h2;
  localparam logic [2:0] IDX_OC_THR = 3'h3;
  localparam logic [2:0] IDX_OC_TMR = 3'h4;
  localparam logic [2:0] IDX_GATE = 3'h5;
  localparam logic [2:0] IDX_PG_THR = 3'h6;

  // reset value of every register before the nonvolatile load
  localparam logic [7:0] CFG_RESET = 8'h00;

  // field positions
  localparam int FLD_UP_LSB = 6;
  localparam int FLD_DOWN_LSB = 4;
  localparam int FLD_OC_TMR_LSB = 6;
  localparam int FLD_OC_EN_MSB = 5;
  localparam int FLD_GATE_LSB = 5;
  localparam int FLD_OC_FLAG_MSB = 3;
  localparam int FLD_RAMP_HI_LSB = 4;

  // timer values in microseconds
  localparam int T_25US_US = 25;
  localparam int T_12P5MS_US = 12500;
  localparam int T_25MS_US = 25000;
  localparam int T_50MS_US = 50000;
  localparam int T_100MS_US = 100000;
  localparam int T_200MS_US = 200000;
  localparam int T_400MS_US = 400000;
  localparam int T_1600MS_US = 1600000;

  // thresholds in tenths of a percent
  localparam logic [9:0] THR_975 = 10'h3cf;
  localparam logic [9:0] THR_950 = 10'h3b6;
  localparam logic [9:0] THR_925 = 10'h39d;
  localparam logic [9:0] THR_900 = 10'h384;
  localparam logic [9:0] THR_875 = 10'h36b;

  // two-bit fault timeout code to microseconds
  function automatic int fault_us(input logic [1:0] code);
    unique case (code)
      2'b00: fault_us = T_25MS_US;
      2'b01: fault_us = T_50MS_US;
      2'b10: fault_us = T_100MS_US;
      2'b11: fault_us = T_200MS_US;
    endcase
  endfunction : fault_us

  // two-bit overcurrent timer code to microseconds
  function automatic int oc_timer_us(input logic [1:0] code);
    unique case (code)
      2'b00: oc_timer_us = T_12P5MS_US;
      2'b01: oc_timer_us = T_50MS_US;
      2'b10: oc_timer_us = T_100MS_US;
      2'b11: oc_timer_us = T_200MS_US;
    endcase
  endfunction : oc_timer_us

  // three-bit timer code to microseconds
  function automatic int timer3_us(input logic [2:0] code);
    unique case (code)
      3'b000: timer3_us = T_25US_US;
      3'b001: timer3_us = T_12P5MS_US;
      3'b010: timer3_us = T_25MS_US;
      3'b011: timer3_us = T_50MS_US;
      3'b100: timer3_us = T_100MS_US;
      3'b101: timer3_us = T_200MS_US;
      3'b110: timer3_us = T_400MS_US;
      3'b111: timer3_us = T_1600MS_US;
    endcase
  endfunction : timer3_us

endpackage : seq_cfg_pkg

// *** design/nv_shadow_mem.sv ***
// small nonvolatile shadow store for the configuration registers
// assumes one writer and one reader per cycle; contents survive srst
`timescale 1ns/1ps
module nv_shadow_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 7,
  parameter int AW = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read side, data one cycle after the address
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_ff
);

  // blank part comes up holding the init word; set in the declaration so the
  // clocked process below stays the only process that writes the store
  logic [WIDTH-1:0] mem [DEPTH] = '{default: INIT};

  // no reset on purpose: the store must keep its words across srst
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_ff <= mem[raddr];
  end

endmodule : nv_shadow_mem

// *** design/cfg_field_decode.sv ***
// decodes configuration fields into cycle counts, thresholds and enables
// purely combinational; the caller registers every result
`timescale 1ns/1ps
module cfg_field_decode
  import seq_cfg_pkg::*;
#(
  parameter int TICKS_PER_US = seq_cfg_pkg::CLK_MHZ
) (
  // raw register contents
  input wire logic [7:0] fault_cfg,
  input wire logic [7:0] oc_thr_cfg,
  input wire logic [7:0] oc_tmr_cfg,
  input wire logic [7:0] gate_cfg,
  input wire logic [7:0] pg_cfg,
  // decoded timers in clock cycles
  output logic [31:0] up_cyc,
  output logic [31:0] down_cyc,
  output logic [31:0] oc_tmr_cyc,
  output logic [31:0] gate_cyc,
  // per channel, channel one lowest
  output logic [4*10-1:0] oc_thr,
  output logic [4*10-1:0] pg_thr,
  output logic [3:0] oc_en
);

  // timers scaled from microseconds to cycles
  always_comb begin
    up_cyc = 32'(fault_us(fault_cfg[FLD_UP_LSB +: 2]) * TICKS_PER_US);
    down_cyc = 32'(fault_us(fault_cfg[FLD_DOWN_LSB +: 2]) * TICKS_PER_US);
    oc_tmr_cyc = 32'(oc_timer_us(oc_tmr_cfg[FLD_OC_TMR_LSB +: 2]) * TICKS_PER_US);
    gate_cyc = 32'(timer3_us(gate_cfg[FLD_GATE_LSB +: 3]) * TICKS_PER_US);
  end

  // per-channel threshold and enable decode
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    always_comb begin
      unique case (oc_thr_cfg[2*ch +: 2])
        2'b00: oc_thr[10*ch +: 10] = THR_975;
        2'b01: oc_thr[10*ch +: 10] = THR_950;
        2'b10: oc_thr[10*ch +: 10] = THR_925;
        2'b11: oc_thr[10*ch +: 10] = THR_900;
      endcase
      unique case (pg_cfg[2*ch +: 2])
        2'b00: pg_thr[10*ch +: 10] = THR_950;
        2'b01: pg_thr[10*ch +: 10] = THR_925;
        2'b10: pg_thr[10*ch +: 10] = THR_900;
        2'b11: pg_thr[10*ch +: 10] = THR_875;
      endcase
      oc_en[ch] = oc_tmr_cfg[FLD_OC_EN_MSB - ch];
    end
  end

endmodule : cfg_field_decode

// *** design/seq_cfg_regs.sv ***
// configuration and status register bank of a four-channel supply sequencer
// assumes a simple register port (address, read and write strobes) fed by
// the serial engine, and overcurrent comparator levels synchronous to clk
`timescale 1ns/1ps
module seq_cfg_regs #(
  parameter int TICKS_PER_US = seq_cfg_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  output logic load_done_ff,
  // overcurrent comparator levels, bit 0 is channel one
  input wire logic [3:0] oc_detect,
  // decoded configuration
  output logic [31:0] fault_up_cyc_ff,
  output logic [31:0] fault_down_cyc_ff,
  output logic [31:0] oc_timer_cyc_ff,
  output logic [31:0] first_gate_delay_cyc_ff,
  output logic [3:0] ramp_one_members_ff,
  output logic [3:0] ramp_two_members_ff,
  output logic [3:0] ramp_three_members_ff,
  output logic [3:0] ramp_four_members_ff,
  output logic [39:0] oc_threshold_ff,
  output logic [39:0] pg_threshold_ff,
  output logic [3:0] oc_monitor_en_ff,
  // overcurrent status, bit 0 is channel one
  output logic [3:0] oc_flag_ff
);
  import seq_cfg_pkg::*;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_LAST = 2'b01,
    ST_RUN = 2'b10
  } load_state_t;

  load_state_t state_ff, nxt_state;
  logic [2:0] ld_idx_ff, nxt_ld_idx;
  logic [2:0] ld_widx_ff, nxt_ld_widx;
  logic ld_pend_ff, nxt_ld_pend;
  logic nxt_load_done;
  logic [7:0] cfg_ff [NUM_REGS];
  logic [7:0] nxt_cfg [NUM_REGS];
  logic rd_pend_ff, nxt_rd_pend;
  logic rd_nv_ff, nxt_rd_nv;
  logic [7:0] rd_stage_ff, nxt_rd_stage;
  logic [7:0] nxt_rdata;
  logic nxt_rvalid;
  logic [7:0] reg_off, nv_off;
  logic reg_hit, nv_hit, host_ok;
  logic mem_we;
  logic [2:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [3:0] flags_rev;
  logic [31:0] dec_up, dec_down, dec_oc_tmr, dec_gate;
  logic [39:0] dec_oc_thr, dec_pg_thr;
  logic [3:0] dec_oc_en;

  // address decode; the bank and its shadow are both seven words
  always_comb begin
    reg_off = reg_addr - ADDR_FAULT_TIMEOUT;
    nv_off = reg_addr - (ADDR_FAULT_TIMEOUT + NV_OFFSET);
    reg_hit = reg_addr >= ADDR_FAULT_TIMEOUT && reg_addr <= ADDR_PG_THRESHOLD;
    nv_hit = reg_addr >= (ADDR_FAULT_TIMEOUT + NV_OFFSET) && reg_addr <= (ADDR_PG_THRESHOLD + NV_OFFSET);
    host_ok = load_done_ff; // host is ignored until the startup load ends
    mem_we = host_ok && reg_wr && nv_hit;
    mem_raddr = host_ok ? nv_off[2:0] : ld_idx_ff;
  end

  // shadow store holding the power-on configuration
  nv_shadow_mem #(
    .WIDTH(8),
    .DEPTH(NUM_REGS),
    .AW(3),
    .INIT(CFG_RESET)
  ) u_nv (
    .clk(clk),
    .we(mem_we),
    .waddr(nv_off[2:0]),
    .wdata(reg_wdata),
    .raddr(mem_raddr),
    .rdata_ff(mem_rdata)
  );

  // startup load walks the shadow one word per cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_ld_idx = ld_idx_ff;
    nxt_ld_pend = 1'b0;
    nxt_ld_widx = ld_idx_ff;
    nxt_load_done = load_done_ff;
    unique case (state_ff)
      ST_LOAD: begin
        nxt_ld_pend = 1'b1;
        nxt_ld_idx = ld_idx_ff + 3'h1;
        if (ld_idx_ff == 3'(NUM_REGS - 1)) begin
          nxt_state = ST_LAST;
        end
      end
      ST_LAST: begin
        nxt_state = ST_RUN;
        nxt_load_done = 1'b1;
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_LOAD;
      ld_idx_ff <= 3'h0;
      ld_widx_ff <= 3'h0;
      ld_pend_ff <= 1'b0;
      load_done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ld_idx_ff <= nxt_ld_idx;
      ld_widx_ff <= nxt_ld_widx;
      ld_pend_ff <= nxt_ld_pend;
      load_done_ff <= nxt_load_done;
    end
  end

  // register writes from the host or the load; the flag bits of the
  // gate delay word are never stored since they mirror live status
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      nxt_cfg[i] = cfg_ff[i];
    end
    if (ld_pend_ff) begin
      nxt_cfg[ld_widx_ff] = mem_rdata;
    end else if (host_ok && reg_wr && reg_hit) begin
      nxt_cfg[reg_off[2:0]] = reg_wdata;
    end
    nxt_cfg[IDX_GATE][FLD_GATE_LSB-1:0] = '0;
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (srst) begin
        cfg_ff[i] <= CFG_RESET;
      end else begin
        cfg_ff[i] <= nxt_cfg[i];
      end
    end
  end

  // status flags are wired to channel order reversed in the word
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      flags_rev[FLD_OC_FLAG_MSB - c] = oc_flag_ff[c];
    end
  end

  // reads answer two cycles after the strobe for both the bank and shadow,
  // so the host sees one latency regardless of where the word lives
  always_comb begin
    nxt_rd_pend = host_ok && reg_rd;
    nxt_rd_nv = nv_hit;
    nxt_rd_stage = 8'h00; // unmapped addresses read zero
    if (reg_hit) begin
      nxt_rd_stage = cfg_ff[reg_off[2:0]];
      if (reg_off[2:0] == IDX_GATE) begin
        nxt_rd_stage[FLD_OC_FLAG_MSB:0] = flags_rev;
      end
    end
    nxt_rvalid = rd_pend_ff;
    nxt_rdata = rd_pend_ff ? (rd_nv_ff ? mem_rdata : rd_stage_ff) : reg_rdata_ff;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_pend_ff <= 1'b0;
      rd_nv_ff <= 1'b0;
      rd_stage_ff <= 8'h00;
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else begin
      rd_pend_ff <= nxt_rd_pend;
      rd_nv_ff <= nxt_rd_nv;
      rd_stage_ff <= nxt_rd_stage;
      reg_rdata_ff <= nxt_rdata;
      reg_rvalid_ff <= nxt_rvalid;
    end
  end

  // field decode, registered below so every output is a flop
  cfg_field_decode #(
    .TICKS_PER_US(TICKS_PER_US)
  ) u_dec (
    .fault_cfg(cfg_ff[IDX_FAULT]),
    .oc_thr_cfg(cfg_ff[IDX_OC_THR]),
    .oc_tmr_cfg(cfg_ff[IDX_OC_TMR]),
    .gate_cfg(cfg_ff[IDX_GATE]),
    .pg_cfg(cfg_ff[IDX_PG_THR]),
    .up_cyc(dec_up),
    .down_cyc(dec_down),
    .oc_tmr_cyc(dec_oc_tmr),
    .gate_cyc(dec_gate),
    .oc_thr(dec_oc_thr),
    .pg_thr(dec_pg_thr),
    .oc_en(dec_oc_en)
  );

  // decoded outputs; flags are gated by enables taken from the same word
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_up_cyc_ff <= '0;
      fault_down_cyc_ff <= '0;
      oc_timer_cyc_ff <= '0;
      first_gate_delay_cyc_ff <= '0;
      ramp_one_members_ff <= 4'h0;
      ramp_two_members_ff <= 4'h0;
      ramp_three_members_ff <= 4'h0;
      ramp_four_members_ff <= 4'h0;
      oc_threshold_ff <= '0;
      pg_threshold_ff <= '0;
      oc_monitor_en_ff <= 4'h0;
      oc_flag_ff <= 4'h0;
    end else begin
      fault_up_cyc_ff <= dec_up;
      fault_down_cyc_ff <= dec_down;
      oc_timer_cyc_ff <= dec_oc_tmr;
      first_gate_delay_cyc_ff <= dec_gate;
      ramp_one_members_ff <= cfg_ff[IDX_RAMP12][FLD_RAMP_HI_LSB-1:0];
      ramp_two_members_ff <= cfg_ff[IDX_RAMP12][7:FLD_RAMP_HI_LSB];
      ramp_three_members_ff <= cfg_ff[IDX_RAMP34][FLD_RAMP_HI_LSB-1:0];
      ramp_four_members_ff <= cfg_ff[IDX_RAMP34][7:FLD_RAMP_HI_LSB];
      oc_threshold_ff <= dec_oc_thr;
      pg_threshold_ff <= dec_pg_thr;
      oc_monitor_en_ff <= dec_oc_en;
      oc_flag_ff <= oc_detect & dec_oc_en;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_UP_TIMEOUT: assert property (
    reg_wr && load_done_ff && reg_addr == ADDR_FAULT_TIMEOUT && reg_wdata[7:6] == 2'b11
    |-> ##2 fault_up_cyc_ff == 32'(T_200MS_US * TICKS_PER_US))
    else $error("power-up timeout not 200 ms after code 11");
  AST_DOWN_TIMEOUT: assert property (
    reg_wr && load_done_ff && reg_addr == ADDR_FAULT_TIMEOUT && reg_wdata[5:4] == 2'b00
    |-> ##2 fault_down_cyc_ff == 32'(T_25MS_US * TICKS_PER_US))
    else $error("power-down timeout not 25 ms after code 00");
  AST_RAMP_TWO: assert property (
    reg_wr && load_done_ff && reg_addr == ADDR_RAMP_ONE_TWO
    |-> ##2 ramp_two_members_ff == $past(reg_wdata[7:4], 2) && ramp_one_members_ff == $past(reg_wdata[3:0], 2))
    else $error("ramp one/two membership does not follow write");
  AST_RAMP_FOUR: assert property (
    reg_wr && load_done_ff && reg_addr == ADDR_RAMP_THREE_FOUR
    |-> ##2 ramp_four_members_ff == $past(reg_wdata[7:4], 2) && ramp_three_members_ff == $past(reg_wdata[3:0], 2))
    else $error("ramp three/four membership does not follow write");
  AST_OC_THR: assert property (
    reg_wr && load_done_ff && reg_addr == ADDR_OC_THRESHOLD && reg_wdata[1:0] == 2'b11
    |-> ##2 oc_threshold_ff[9:0] == THR_900)
    else $error("channel one overcurrent threshold not 90 percent");
  AST_OC_TIMER: assert property (
    reg_wr && load_done_ff && reg_addr == ADDR_OC_TIMER_ENABLE && reg_wdata[7:6] == 2'b00
    |-> ##2 oc_timer_cyc_ff == 32'(T_12P5MS_US * TICKS_PER_US))
    else $error("overcurrent timer not 12.5 ms after code 00");
  AST_OC_GATE: assert property (
    oc_flag_ff == ($past(oc_detect) & oc_monitor_en_ff))
    else $error("overcurrent flags do not follow comparators and enables");
  AST_GATE_400: assert property (
    reg_wr && load_done_ff && reg_addr == ADDR_GATE_DELAY_FLAGS && reg_wdata[7:5] == 3'b110
    |-> ##2 first_gate_delay_cyc_ff == 32'(T_400MS_US * TICKS_PER_US))
    else $error("gate delay not 400 ms after code 110");
  AST_GATE_1600: assert property (
    reg_wr && load_done_ff && reg_addr == ADDR_GATE_DELAY_FLAGS && reg_wdata[7:5] == 3'b111
    |-> ##2 first_gate_delay_cyc_ff == 32'(T_1600MS_US * TICKS_PER_US))
    else $error("gate delay not 1600 ms after code 111");
  AST_FLAG_READ: assert property (
    reg_rd && load_done_ff && reg_addr == ADDR_GATE_DELAY_FLAGS
    |-> ##2 reg_rvalid_ff && reg_rdata_ff[3] == $past(oc_flag_ff[0], 2) && reg_rdata_ff[0] == $past(oc_flag_ff[3], 2))
    else $error("overcurrent flags read back wrong");
  AST_PG_THR: assert property (
    reg_wr && load_done_ff && reg_addr == ADDR_PG_THRESHOLD && reg_wdata[7:6] == 2'b11
    |-> ##2 pg_threshold_ff[39:30] == THR_875)
    else $error("channel four power-good threshold not 87.5 percent");
  AST_LOAD_DONE: assert property (
    $fell(srst) |-> ##[8:10] load_done_ff)
    else $error("startup load did not finish in time");

endmodule : seq_cfg_regs

// *** verif/host_model.sv ***
// host side model of the register port: one access at a time, each strobe held high for one cycle
// assumes the device takes a request at the edge where the strobe is high
`timescale 1ns/1ps
module host_model
  import seq_cfg_pkg::*;
(
  // clock
  input wire logic clk,
  // requests toward the device
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  // read answer
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  // idle values at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // one write; a write to the shadow copy of the timeout word always has its reserved nibble cleared
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= (a == (ADDR_FAULT_TIMEOUT + NV_OFFSET)) ? {d[7:4], 4'h0} : d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // released lines show the inverse so stale values never look valid
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // one read; the answer is looked at in the single cycle it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    #1;
    ok = reg_rvalid_ff;
    d = reg_rdata_ff;
  endtask : rd
endmodule : host_model

// *** verif/seq_cfg_regs_bench.sv ***
// self-checking bench for the sequencer configuration and status register bank
// assumes timers scaled to one tick per microsecond and a zeroed shadow store at start
`timescale 1ns/1ps
module seq_cfg_regs_bench;
  import seq_cfg_pkg::*;
  logic clk, srst, reg_wr, reg_rd, reg_rvalid_ff, load_done_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, rv;
  logic [3:0] oc_detect, oc_monitor_en_ff, oc_flag_ff, r1, r2, r3, r4;
  logic [31:0] up_c, down_c, oct_c, gate_c;
  logic [39:0] oc_thr, pg_thr;
  logic [7:0] v [7];
  logic ok;
  int err_total, n_checks;

  seq_cfg_regs #(.TICKS_PER_US(1)) seq_cfg_regs_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .load_done_ff(load_done_ff), .oc_detect(oc_detect),
    .fault_up_cyc_ff(up_c), .fault_down_cyc_ff(down_c), .oc_timer_cyc_ff(oct_c),
    .first_gate_delay_cyc_ff(gate_c), .ramp_one_members_ff(r1), .ramp_two_members_ff(r2),
    .ramp_three_members_ff(r3), .ramp_four_members_ff(r4), .oc_threshold_ff(oc_thr),
    .pg_threshold_ff(pg_thr), .oc_monitor_en_ff(oc_monitor_en_ff), .oc_flag_ff(oc_flag_ff));
  host_model host_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff));

  // clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // expected timer lengths in microseconds
  function automatic logic [31:0] exp_fault(input logic [1:0] c);
    return 32'(T_25MS_US) << c;
  endfunction : exp_fault
  function automatic logic [31:0] exp_oct(input logic [1:0] c);
    return (c == 2'b00) ? 32'(T_12P5MS_US) : 32'(T_25MS_US) << c;
  endfunction : exp_oct
  function automatic logic [31:0] exp_gate(input logic [2:0] c);
    if (c == 3'b000) return 32'(T_25US_US);
    if (c == 3'b111) return 32'(T_1600MS_US);
    return 32'(T_12P5MS_US) << (c - 3'd1);
  endfunction : exp_gate

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host_model_inst.rd(a, rv, ok);
    chk(40'(ok), 40'h1, "read answer valid");
    chk(40'(rv), 40'(exp), "read data");
  endtask : rdchk

  // decoded outputs land one edge after the write is taken, two after the strobe is raised
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic wait_load();
    for (int i = 0; i < 20 && load_done_ff !== 1'b1; i++) @(posedge clk);
    chk(40'(load_done_ff), 40'h1, "startup load finished");
  endtask : wait_load

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // watchdog, far beyond the roughly six hundred cycles the tests need
  initial begin
    #400us;
    err_total++;
    finish_test();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    oc_detect = 4'h0;
    void'($urandom(40));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    wait_load();
    chk(40'(r1), 40'h0, "ramp one after blank load");
    rdchk(ADDR_FAULT_TIMEOUT, 8'h00);
    $display("test reset and load done");
    // every timer code, power-down code runs opposite to power-up
    for (int c = 0; c < 4; c++) begin
      host_model_inst.wr(ADDR_FAULT_TIMEOUT, {2'(c), ~2'(c), 4'h9});
      host_model_inst.wr(ADDR_OC_TIMER_ENABLE, {2'(c), 6'h3c});
      settle();
      chk(40'(up_c), 40'(exp_fault(2'(c))), "power-up timeout");
      chk(40'(down_c), 40'(exp_fault(~2'(c))), "power-down timeout");
      chk(40'(oct_c), 40'(exp_oct(2'(c))), "overcurrent timer");
    end
    for (int c = 0; c < 8; c++) begin
      host_model_inst.wr(ADDR_GATE_DELAY_FLAGS, {3'(c), 5'h1f});
      settle();
      chk(40'(gate_c), 40'(exp_gate(3'(c))), "first gate delay");
      rdchk(ADDR_GATE_DELAY_FLAGS, {3'(c), 5'h00});
    end
    $display("test timer codes done");
    // random membership, thresholds and enables, written back to back
    for (int n = 0; n < 16; n++) begin
      foreach (v[i]) v[i] = 8'($urandom);
      for (int i = 0; i < 5; i++) host_model_inst.wr(ADDR_RAMP_ONE_TWO + 8'(i), v[i]);
      host_model_inst.wr(ADDR_PG_THRESHOLD, v[5]);
      settle();
      chk(40'({r2, r1}), 40'(v[0]), "ramps one and two");
      chk(40'({r4, r3}), 40'(v[1]), "ramps three and four");
      for (int ch = 0; ch < 4; ch++) begin
        chk(40'(oc_thr[ch*10+:10]), 40'(975 - 25 * v[2][ch*2+:2]), "overcurrent threshold");
        chk(40'(pg_thr[ch*10+:10]), 40'(950 - 25 * v[5][ch*2+:2]), "power-good threshold");
        chk(40'(oc_monitor_en_ff[ch]), 40'(v[3][5-ch]), "overcurrent enable");
      end
      rdchk(ADDR_OC_TIMER_ENABLE, v[3]);
      rdchk(ADDR_PG_THRESHOLD, v[5]);
      // live flags follow the comparators only where monitoring is on
      @(posedge clk);
      oc_detect <= v[4][3:0];
      settle();
      chk(40'(oc_flag_ff), 40'(v[4][3:0] & {v[3][2], v[3][3], v[3][4], v[3][5]}), "flags");
      // gate word was written with v[4]; flag bits come from stimulus and enables
      rdchk(ADDR_GATE_DELAY_FLAGS, {v[4][7:5], 1'b0, v[4][0] & v[3][5], v[4][1] & v[3][4],
        v[4][2] & v[3][3], v[4][3] & v[3][2]});
    end
    @(posedge clk);
    oc_detect <= 4'h0;
    rdchk(8'h11, 8'h00);
    $display("test random fields done");
    // shadow copy: no effect until the next reset, then loaded
    foreach (v[i]) v[i] = 8'($urandom);
    foreach (v[i]) host_model_inst.wr(ADDR_FAULT_TIMEOUT + NV_OFFSET + 8'(i), v[i]);
    v[0][3:0] = 4'h0;
    v[5][4:0] = 5'h00;
    rdchk(ADDR_FAULT_TIMEOUT + NV_OFFSET, v[0]);
    rdchk(ADDR_RAMP_THREE_FOUR + NV_OFFSET, v[2]);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wait_load();
    foreach (v[i]) rdchk(ADDR_FAULT_TIMEOUT + 8'(i), v[i]);
    settle();
    chk(40'({r4, r3}), 40'(v[2]), "ramps after load");
    $display("test shadow load done");
    finish_test();
  end
endmodule : seq_cfg_regs_bench
